// ===== design/uv_fault_pkg.sv
// constants, codes and decode helpers for the output undervoltage fault handler
// assumes a command decoder that turns host transactions into single-cycle register strobes
package uv_fault_pkg;
    // command codes of the two registers
    localparam logic [7:0]  CMD_UV_THRESHOLD = 8'h44;
    localparam logic [7:0]  CMD_UV_ACTION    = 8'h45;
    // reset values; the fraction is held with a weight of 2^-9
    localparam logic [15:0] UV_THRESHOLD_RST = 16'h01C0;
    localparam logic [7:0]  UV_ACTION_RST    = 8'h80;
    localparam int          LIN_EXP_SHIFT    = 9;
    localparam int          PROD_W           = 32;
    // action field positions
    localparam int          RESP_HI          = 7;
    localparam int          RESP_LO          = 6;
    localparam int          RETRY_HI         = 5;
    localparam int          RETRY_LO         = 3;
    localparam int          DLY_HI           = 2;
    localparam int          DLY_LO           = 0;
    // response codes; the top bit alone marks an immediate shutdown
    localparam logic [1:0]  RESP_IGNORE      = 2'h0;
    localparam logic [1:0]  RESP_AFTER_DELAY = 2'h1;
    localparam int          RESP_NOW_BIT     = 1;
    localparam logic [2:0]  RETRY_NONE       = 3'h0;
    localparam logic [2:0]  RETRY_FOREVER    = 3'h7;
    // delay field decode
    localparam logic [2:0]  DLY_CODE_MID     = 3'h2;
    localparam logic [2:0]  DLY_CODE_HIGH    = 3'h5;
    localparam logic [2:0]  DLY_PER_SHORT    = 3'h1;
    localparam logic [2:0]  DLY_PER_MID      = 3'h3;
    localparam logic [2:0]  DLY_PER_LONG     = 3'h7;
    localparam logic [2:0]  HIC_MULT_MIN     = 3'h1;
    localparam int          RAMP_W           = 16;
    localparam int          HIC_W            = 19;

    typedef enum logic [2:0] {
        ST_OFF    = 3'h0,
        ST_RUN    = 3'h1,
        ST_DELAY  = 3'h3,
        ST_RESTART_INTERVAL = 3'h2,
        ST_LATCH  = 3'h6
    } state_e;

    function automatic logic [2:0] shutdown_periods(input logic [2:0] code);
        if (code < DLY_CODE_MID) begin
            return DLY_PER_SHORT;
        end else if (code < DLY_CODE_HIGH) begin
            return DLY_PER_MID;
        end
        return DLY_PER_LONG;
    endfunction

    function automatic logic [2:0] restart_interval_mult(input logic [2:0] code);
        return (code < DLY_CODE_MID) ? HIC_MULT_MIN : code;
    endfunction
endpackage

// ===== design/uv_threshold_cmp.sv
// scales the stored fraction onto the live output target and compares the measured output
// assumes target and measurement come from logic on the same clock, both with weight 2^-9
`timescale 1ns/10ps
module uv_threshold_cmp (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [15:0] vout_target,
    input  wire logic [15:0] threshold,
    input  wire logic [15:0] vout_meas,
    output logic             uv_detect
);
    import uv_fault_pkg::*;

    typedef struct packed {
        logic [15:0] trip;
        logic        det;
    } cmp_s;

    cmp_s                s_ff;
    cmp_s                nxt_s;
    logic [PROD_W-1:0]   prod;

    // product recomputed every cycle so the trip level follows target changes
    assign prod = {16'h0000, vout_target} * {16'h0000, threshold};

    always_comb begin
        nxt_s      = s_ff;
        nxt_s.trip = prod[LIN_EXP_SHIFT +: 16];
        nxt_s.det  = vout_meas < s_ff.trip;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign uv_detect = s_ff.det;
endmodule

// ===== design/uv_fault_handler.sv
// output undervoltage fault handler: threshold and action registers, response, retry, restart_interval
// assumes strobes, pwm tick, ramp time and measurements all arrive on clk
//
// Summary of operation
// - threshold register is 16-bit unsigned, output-voltage linear format, exponent -9
// - trip level is a fraction of the live output target and follows it
// - every response code drives alert low and sets the undervoltage status bit
// - code 00 ignores, 01 shuts down after delay, 10 shuts down at once
// - retry 000 never restarts; output stays off until faults are cleared
// - retry 1 to 6 restarts that often, then stays off until reset
// - retry 111 restarts without limit until disabled or another fault
// - delay codes 0-1 give 1, 2-4 give 3, 5-7 give 7 pwm periods
// - restart_interval is one ramp time for codes 0-1, else code times ramp time
`timescale 1ns/10ps
module uv_fault_handler (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic                       cmd_wr,
    input  wire logic                       cmd_rd,
    input  wire logic [7:0]                 cmd_code,
    input  wire logic [15:0]                cmd_wdata,
    input  wire logic                       clear_faults,
    input  wire logic                       output_on,
    input  wire logic                       other_fault,
    input  wire logic                       pwm_tick,
    input  wire logic [uv_fault_pkg::RAMP_W-1:0] output_ramp_up_time,
    input  wire logic [15:0]                vout_target,
    input  wire logic [15:0]                vout_meas,
    output logic                            alert_output_b,
    output logic                            uv_fault_flag,
    output logic                            stage_enable,
    output logic [15:0]                     rd_data,
    output logic                            rd_valid
);
    import uv_fault_pkg::*;

    typedef struct packed {
        logic [15:0]      threshold;
        logic [7:0]       action;
        state_e           st;
        logic [2:0]       dly_cnt;
        logic [HIC_W-1:0] hic_cnt;
        logic [2:0]       tries;
        logic             hard_latch;
        logic             uv_status;
        logic             alert_b;
        logic             stage_en;
        logic [15:0]      rdata;
        logic             rvalid;
    } hdl_s;

    hdl_s             s_ff;
    hdl_s             nxt_s;
    logic             uv_det;
    logic [1:0]       resp;
    logic [2:0]       retry;
    logic [2:0]       dly_code;
    logic [2:0]       dly_len;
    logic [HIC_W-1:0] hic_len;
    logic             running;
    logic             fault_ev;
    logic             shut_req;

    uv_threshold_cmp u_cmp (
        .clk         (clk),
        .rst_b       (rst_b),
        .vout_target (vout_target),
        .threshold   (s_ff.threshold),
        .vout_meas   (vout_meas),
        .uv_detect   (uv_det)
    );

    assign resp     = s_ff.action[RESP_HI:RESP_LO];
    assign retry    = s_ff.action[RETRY_HI:RETRY_LO];
    assign dly_code = s_ff.action[DLY_HI:DLY_LO];
    assign dly_len  = shutdown_periods(dly_code);
    // a zero ramp time still yields a one-cycle restart_interval through the compare below
    assign hic_len  = HIC_W'({16'h0000, restart_interval_mult(dly_code)} * {3'h0, output_ramp_up_time});
    assign running  = (s_ff.st == ST_RUN) || (s_ff.st == ST_DELAY);
    assign fault_ev = running && uv_det;
    assign shut_req = (s_ff.st == ST_RUN) && uv_det && resp[RESP_NOW_BIT];

    always_comb begin
        nxt_s        = s_ff;
        nxt_s.rvalid = 1'b0;

        if (cmd_wr && cmd_code == CMD_UV_THRESHOLD) begin
            nxt_s.threshold = cmd_wdata;
        end
        if (cmd_wr && cmd_code == CMD_UV_ACTION) begin
            nxt_s.action = cmd_wdata[7:0];
        end
        if (cmd_rd) begin
            nxt_s.rvalid = 1'b1;
            case (cmd_code)
                CMD_UV_THRESHOLD: nxt_s.rdata = s_ff.threshold;
                CMD_UV_ACTION:    nxt_s.rdata = {8'h00, s_ff.action};
                default:          nxt_s.rdata = 16'h0000;
            endcase
        end

        // a fault in the same cycle as a clear keeps the flag set
        nxt_s.uv_status = (s_ff.uv_status && !clear_faults) || fault_ev;
        nxt_s.alert_b   = !nxt_s.uv_status;

        case (s_ff.st)
            ST_OFF: begin
                nxt_s.dly_cnt = 3'h0;
                if (output_on && !s_ff.hard_latch) begin
                    nxt_s.st = ST_RUN;
                end
            end
            ST_RUN: begin
                nxt_s.dly_cnt = 3'h0;
                if (uv_det && resp == RESP_AFTER_DELAY) begin
                    nxt_s.st = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (pwm_tick) begin
                    nxt_s.dly_cnt = s_ff.dly_cnt + 3'h1;
                end
            end
            ST_RESTART_INTERVAL: begin
                nxt_s.hic_cnt = s_ff.hic_cnt + HIC_W'(1);
                if (s_ff.hic_cnt + HIC_W'(1) >= hic_len) begin
                    nxt_s.st = ST_RUN;
                end
            end
            ST_LATCH: begin
                // soft latch leaves on a clear, the retry-exhausted latch only on reset
                if (clear_faults && !s_ff.hard_latch) begin
                    nxt_s.st = ST_OFF;
                end
            end
            default: begin
                nxt_s.st = ST_OFF;
            end
        endcase

        // shutdown from the immediate path or at the end of the delay
        if (shut_req || (s_ff.st == ST_DELAY && pwm_tick && s_ff.dly_cnt + 3'h1 >= dly_len)) begin
            nxt_s.hic_cnt = '0;
            if (retry == RETRY_NONE) begin
                nxt_s.st = ST_LATCH;
            end else if (retry == RETRY_FOREVER) begin
                nxt_s.st = ST_RESTART_INTERVAL;
            end else if (s_ff.tries < retry) begin
                nxt_s.st    = ST_RESTART_INTERVAL;
                nxt_s.tries = s_ff.tries + 3'h1;
            end else begin
                nxt_s.st         = ST_LATCH;
                nxt_s.hard_latch = 1'b1;
            end
        end

        // another fault or a disable ends any retry sequence
        if (other_fault && s_ff.st != ST_OFF && s_ff.st != ST_LATCH) begin
            nxt_s.st = ST_LATCH;
        end else if (!output_on && s_ff.st != ST_LATCH) begin
            nxt_s.st    = ST_OFF;
            nxt_s.tries = 3'h0;
        end

        nxt_s.stage_en = (nxt_s.st == ST_RUN) || (nxt_s.st == ST_DELAY);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_ff           <= '0;
            s_ff.threshold <= UV_THRESHOLD_RST;
            s_ff.action    <= UV_ACTION_RST;
            s_ff.st        <= ST_OFF;
            s_ff.alert_b   <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign alert_output_b = s_ff.alert_b;
    assign uv_fault_flag  = s_ff.uv_status;
    assign stage_enable   = s_ff.stage_en;
    assign rd_data        = s_ff.rdata;
    assign rd_valid       = s_ff.rvalid;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_uv_in_run;
        s_ff.st == ST_RUN && uv_det && !other_fault && output_on;
    endsequence

    sequence s_end_of_delay;
        s_ff.st == ST_DELAY && pwm_tick && (s_ff.dly_cnt + 3'h1 >= dly_len)
            && !other_fault && output_on;
    endsequence

    AST_ALERT_WITH_STATUS: assert property (
        uv_fault_flag |-> !alert_output_b
    ) else $error("alert high while fault flag set");

    AST_STATUS_ON_FAULT: assert property (
        fault_ev |=> uv_fault_flag && !alert_output_b
    ) else $error("fault did not raise flag and alert");

    AST_IGNORE_KEEPS_ON: assert property (
        s_uv_in_run and (resp == RESP_IGNORE) |=> stage_enable && s_ff.st == ST_RUN
    ) else $error("ignore response interrupted the output");

    AST_DELAY_ENTERED: assert property (
        s_uv_in_run and (resp == RESP_AFTER_DELAY) |=> s_ff.st == ST_DELAY && stage_enable
    ) else $error("delayed response did not start its delay");

    AST_IMMEDIATE_OFF: assert property (
        s_uv_in_run and resp[RESP_NOW_BIT] |=> !stage_enable
    ) else $error("immediate response left the output on");

    AST_LATCH_NO_RETRY: assert property (
        (s_uv_in_run and resp[RESP_NOW_BIT] and (retry == RETRY_NONE))
            |=> s_ff.st == ST_LATCH ##1 (s_ff.st == ST_LATCH || $past(clear_faults))
    ) else $error("latch-off setting attempted a restart");

    AST_HARD_LATCH_HOLDS: assert property (
        s_ff.hard_latch |=> s_ff.hard_latch && !stage_enable
    ) else $error("exhausted retries released the output");

    AST_FOREVER_RETRIES: assert property (
        (s_uv_in_run and resp[RESP_NOW_BIT] and (retry == RETRY_FOREVER))
            |=> s_ff.st == ST_RESTART_INTERVAL && !s_ff.hard_latch
    ) else $error("unlimited retry setting stopped retrying");

    AST_DELAY_LENGTH: assert property (
        s_end_of_delay |=> !stage_enable
    ) else $error("shutdown delay overran its period count");

    AST_DELAY_BOUND: assert property (
        s_ff.st == ST_DELAY |-> s_ff.dly_cnt < dly_len
    ) else $error("delay counter passed its limit");

    AST_RESTART_INTERVAL_BOUND: assert property (
        s_ff.st == ST_RESTART_INTERVAL && !other_fault && output_on && (s_ff.hic_cnt + HIC_W'(1) >= hic_len)
            |=> s_ff.st == ST_RUN && stage_enable
    ) else $error("restart_interval did not end after its interval");

    // register port: every read strobe gets exactly one answer, writes land on the next edge
    AST_READ_ANSWERS: assert property (
        cmd_rd |=> rd_valid
    ) else $error("read strobe got no answer");

    AST_NO_SPURIOUS_ANSWER: assert property (
        !cmd_rd |=> !rd_valid
    ) else $error("answer without a read strobe");

    AST_THRESHOLD_WRITE: assert property (
        cmd_wr && cmd_code == CMD_UV_THRESHOLD |=> s_ff.threshold == $past(cmd_wdata)
    ) else $error("threshold write did not land");

    AST_ACTION_WRITE: assert property (
        cmd_wr && cmd_code == CMD_UV_ACTION |=> s_ff.action == $past(cmd_wdata[7:0])
    ) else $error("action write did not land");

    // the status bit is sticky and a fault beats a clear in the same cycle
    AST_FLAG_STICKY: assert property (
        uv_fault_flag && !clear_faults |=> uv_fault_flag
    ) else $error("fault flag dropped without a clear");

    AST_SET_BEATS_CLEAR: assert property (
        fault_ev && clear_faults |=> uv_fault_flag
    ) else $error("clear in a fault cycle lost the fault");

    AST_NO_FLAG_WHEN_OFF: assert property (
        !running && !uv_fault_flag |=> !uv_fault_flag
    ) else $error("fault flag set while output off");

    AST_STAGE_FROM_STATE: assert property (
        stage_enable |-> s_ff.st == ST_RUN || s_ff.st == ST_DELAY
    ) else $error("stage enabled outside run or delay");

    AST_DELAY_WAITS: assert property (
        s_ff.st == ST_DELAY && !pwm_tick && !other_fault && output_on
            |=> s_ff.st == ST_DELAY && stage_enable
    ) else $error("delay ended without a pwm period");

    AST_RESTART_INTERVAL_NOT_EARLY: assert property (
        s_ff.st == ST_RESTART_INTERVAL && (s_ff.hic_cnt + HIC_W'(1) < hic_len) |=> !stage_enable
    ) else $error("restart_interval ended before its interval");

    AST_SOFT_LATCH_CLEARS: assert property (
        s_ff.st == ST_LATCH && clear_faults && !s_ff.hard_latch |=> s_ff.st == ST_OFF
    ) else $error("clear did not release the latch");

    AST_LATCH_WAITS: assert property (
        s_ff.st == ST_LATCH && !clear_faults |=> s_ff.st == ST_LATCH
    ) else $error("latch released without a clear");

    // an idle handler may still start up under another fault, so every state but ST_OFF counts
    AST_OTHER_FAULT_STOPS: assert property (
        other_fault && s_ff.st != ST_OFF |=> !stage_enable
    ) else $error("another fault left the output on");

    AST_DISABLE_STOPS: assert property (
        !output_on |=> !stage_enable
    ) else $error("disable left the output on");

    sequence s_retries_spent;
        s_ff.st == ST_RUN && uv_det && resp[RESP_NOW_BIT] && retry != RETRY_NONE
            && retry != RETRY_FOREVER && s_ff.tries >= retry;
    endsequence

    AST_RETRIES_EXHAUST: assert property (
        s_retries_spent and (!other_fault && output_on)
            |=> s_ff.hard_latch && s_ff.st == ST_LATCH
    ) else $error("spent retries did not latch the output off");

    AST_RETRY_COUNTS: assert property (
        s_uv_in_run and resp[RESP_NOW_BIT] and (retry != RETRY_NONE)
            and (retry != RETRY_FOREVER) and (s_ff.tries < retry)
            |=> s_ff.st == ST_RESTART_INTERVAL && s_ff.tries == $past(s_ff.tries) + 3'h1
    ) else $error("restart attempt was not counted");
endmodule

// ===== tb/uv_host_model.sv
// host model: turns bench calls into single-cycle register strobes
// assumes the handler samples strobes on the rising edge; we change them on the falling one
`timescale 1ns/10ps
module uv_host_model (
    input  wire logic        clk,
    input  wire logic        rd_valid,
    input  wire logic [15:0] rd_data,
    output logic             cmd_wr,
    output logic             cmd_rd,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata
);
    initial begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end

    task automatic wr(input logic [7:0] c, input logic [15:0] v);
        @(negedge clk);
        cmd_code = c;
        cmd_wdata = v;
        cmd_wr = 1'b1;
        @(negedge clk);
        cmd_wr = 1'b0;
        // released data shows the inverse so a stale sample cannot pass
        cmd_wdata = ~v;
    endtask

    task automatic rd(input logic [7:0] c, output logic [15:0] v);
        @(negedge clk);
        cmd_code = c;
        cmd_rd = 1'b1;
        @(negedge clk);
        cmd_rd = 1'b0;
        v = (rd_valid === 1'b1) ? rd_data : 16'hXXXX;
    endtask
endmodule

// ===== tb/uv_fault_handler_tb.sv
// self-checking bench for the undervoltage fault handler
// assumes the host model for register access; trip level is target * 0x0100 >> 9
`timescale 1ns/10ps
module uv_fault_handler_tb;
    import uv_fault_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b, cmd_wr, cmd_rd, clear_faults, output_on, other_fault, pwm_tick;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, ramp, vout_target, vout_meas, rd_data, d;
    logic        alert_output_b, uv_fault_flag, stage_enable, rd_valid;
    int          errors = 0;
    int          total_checks = 0;
    int          n;
    always #4 clk = ~clk;

    uv_host_model u_uv_host_model (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
        .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
    uv_fault_handler u_uv_fault_handler (.clk(clk), .rst_b(rst_b), .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .clear_faults(clear_faults), .output_on(output_on), .other_fault(other_fault),
        .pwm_tick(pwm_tick), .output_ramp_up_time(ramp), .vout_target(vout_target),
        .vout_meas(vout_meas), .alert_output_b(alert_output_b),
        .uv_fault_flag(uv_fault_flag), .stage_enable(stage_enable), .rd_data(rd_data),
        .rd_valid(rd_valid));

    task automatic summarize;
        if (errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic tick;
        pwm_tick = 1'b1;
        cyc(1);
        pwm_tick = 1'b0;
        cyc(1);
    endtask

    // bounded wait for the stage enable to reach a level, n counts the cycles
    task automatic wait_on(input logic v, input int lim);
        n = 0;
        while (stage_enable !== v && n < lim) begin
            cyc(1);
            n++;
        end
    endtask

    // dropping output_on also clears the retry count unless the handler sits in ST_LATCH, where clear_faults only returns it to ST_OFF
    task automatic arm(input logic [7:0] act);
        output_on = 1'b0;
        vout_meas = 16'h0400;
        u_uv_host_model.wr(CMD_UV_ACTION, {8'h00, act});
        clear_faults = 1'b1;
        cyc(1);
        clear_faults = 1'b0;
        output_on = 1'b1;
        cyc(4);
        chk(16'(stage_enable), 16'h0001);
    endtask

    initial begin
        cyc(20000);
        errors++;
        summarize();
    end

    initial begin
        rst_b = 1'b0;
        clear_faults = 1'b0;
        output_on = 1'b0;
        other_fault = 1'b0;
        pwm_tick = 1'b0;
        ramp = 16'h0004;
        vout_target = 16'h0400;
        vout_meas = 16'h0400;
        cyc(16);
        rst_b = 1'b1;
        cyc(1);
        chk({alert_output_b, uv_fault_flag, stage_enable}, 16'h0004);
        u_uv_host_model.rd(CMD_UV_THRESHOLD, d);
        chk(d, UV_THRESHOLD_RST);
        u_uv_host_model.rd(CMD_UV_ACTION, d);
        chk(d, {8'h00, UV_ACTION_RST});
        u_uv_host_model.rd(8'h46, d);
        chk(d, 16'h0000);
        u_uv_host_model.wr(CMD_UV_THRESHOLD, 16'h0100);
        u_uv_host_model.rd(CMD_UV_THRESHOLD, d);
        chk(d, 16'h0100);
        u_uv_host_model.wr(CMD_UV_ACTION, 16'hFFCD);
        u_uv_host_model.rd(CMD_UV_ACTION, d);
        chk(d, 16'h00CD);
        // just above half of the target, then the target doubles under it
        arm(8'h80);
        vout_meas = 16'h0201;
        cyc(6);
        chk({alert_output_b, uv_fault_flag, stage_enable}, 16'h0005);
        vout_target = 16'h0800;
        cyc(6);
        chk({alert_output_b, uv_fault_flag, stage_enable}, 16'h0002);
        vout_target = 16'h0400;
        for (int r = 0; r < 4; r++) begin
            arm({r[1:0], 6'h00});
            vout_meas = 16'h0100;
            cyc(6);
            chk({alert_output_b, uv_fault_flag}, 16'h0001);
            chk(16'(stage_enable), 16'(r < 2));
            // a clear while the fault persists keeps the flag only for codes 00 and 01, whose output still runs
            clear_faults = 1'b1;
            cyc(1);
            clear_faults = 1'b0;
            cyc(1);
            chk(16'(uv_fault_flag), 16'(r < 2));
        end
        cyc(60);
        chk(16'(stage_enable), 16'h0000);
        vout_meas = 16'h0400;
        clear_faults = 1'b1;
        cyc(1);
        clear_faults = 1'b0;
        cyc(6);
        chk(16'(stage_enable), 16'h0001);
        for (int i = 0; i < 3; i++) begin
            arm({2'b01, 3'b000, i == 0 ? 3'd0 : (i == 1 ? 3'd2 : 3'd5)});
            vout_meas = 16'h0100;
            cyc(4);
            repeat ((i == 0 ? 1 : (i == 1 ? 3 : 7)) - 1) tick();
            cyc(3);
            chk(16'(stage_enable), 16'h0001);
            tick();
            cyc(3);
            chk(16'(stage_enable), 16'h0000);
        end
        // endless retry with a one-ramp restart_interval, stopped by another fault
        arm({2'b10, 3'b111, 3'd0});
        vout_meas = 16'h0100;
        for (int i = 0; i < 9; i++) begin
            wait_on(1'b0, 10);
            wait_on(1'b1, 20);
            chk(16'(n >= 3 && n <= 5), 16'h0001);
        end
        other_fault = 1'b1;
        cyc(50);
        chk(16'(stage_enable), 16'h0000);
        other_fault = 1'b0;
        // one retry, restart_interval three ramps, then hard latch that clearing cannot undo
        arm({2'b10, 3'b001, 3'd3});
        vout_meas = 16'h0100;
        wait_on(1'b0, 10);
        wait_on(1'b1, 40);
        chk(16'(n >= 11 && n <= 13), 16'h0001);
        wait_on(1'b0, 10);
        vout_meas = 16'h0400;
        clear_faults = 1'b1;
        cyc(1);
        clear_faults = 1'b0;
        cyc(100);
        chk(16'(stage_enable), 16'h0000);
        // only a reset releases the exhausted latch; output_on still high restarts at once
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
        cyc(1);
        chk({alert_output_b, uv_fault_flag, stage_enable}, 16'h0005);
        u_uv_host_model.rd(CMD_UV_ACTION, d);
        chk(d, {8'h00, UV_ACTION_RST});
        summarize();
    end
endmodule
